// ==== src/lre_engine.sv ====
`timescale 1ns/100ps
`default_nettype none

module lre_engine
#(
    parameter int FIXED_CYC = lre_pkg::CYCLE_FIXED_CYC,
    parameter int PER_RULE_CYC = lre_pkg::RULE_TIME_CYC
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic start_rule_engine_i,
    input wire logic stop_i,
    output logic running_o,
    input wire logic monitor_en_i,
    input wire logic cfg_we_i,
    input wire logic [lre_pkg::RULE_IDX_W-1:0] cfg_rule_i,
    input wire logic cfg_enable_i,
    input wire logic [lre_pkg::NUM_INPUTS-1:0] cfg_src_flag_i,
    input wire logic [lre_pkg::NUM_INPUTS*lre_pkg::SRC_IDX_W-1:0] cfg_in_idx_i,
    input wire logic [lre_pkg::NUM_INPUTS-1:0] cfg_in_used_i,
    input wire logic [lre_pkg::NUM_INPUTS-1:0] cfg_in_invert_i,
    input wire lre_pkg::lre_op_t cfg_op_i,
    input wire logic cfg_chain_to_next_rule_i,
    input wire lre_pkg::lre_out_kind_t cfg_out_kind_i,
    input wire logic [lre_pkg::SRC_IDX_W-1:0] cfg_out_idx_i,
    input wire logic [lre_pkg::MOD_ID_W-1:0] cfg_out_module_i,
    input wire logic cfg_true_val_i,
    input wire logic [lre_pkg::NUM_HW_IN-1:0] hw_in_i,
    output logic [lre_pkg::NUM_HW_OUT-1:0] hw_out_o,
    output logic [lre_pkg::NUM_FLAGS-1:0] flags_o,
    input wire logic host_flag_we_i,
    input wire logic [lre_pkg::SRC_IDX_W-1:0] host_flag_idx_i,
    input wire logic host_flag_val_i,
    input wire logic net_rx_we_i,
    input wire logic [lre_pkg::SRC_IDX_W-1:0] net_rx_idx_i,
    input wire logic net_rx_val_i,
    output logic net_tx_valid_o,
    input wire logic net_tx_ready_i,
    output logic [lre_pkg::MOD_ID_W-1:0] net_tx_module_o,
    output logic [lre_pkg::SRC_IDX_W-1:0] net_tx_idx_o,
    output logic net_tx_val_o,
    output logic [2*lre_pkg::NUM_RULES-1:0] rule_stage_o,
    output logic [lre_pkg::NUM_INPUTS*lre_pkg::NUM_RULES-1:0] rule_inputs_o
);
    import lre_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Rule storage, sixteen slots of three inputs each

    logic cfg_en [NUM_RULES];
    logic [NUM_INPUTS-1:0] cfg_src [NUM_RULES];
    logic [NUM_INPUTS*SRC_IDX_W-1:0] cfg_idx [NUM_RULES];
    logic [NUM_INPUTS-1:0] cfg_used [NUM_RULES];
    logic [NUM_INPUTS-1:0] cfg_inv [NUM_RULES];
    lre_op_t cfg_op [NUM_RULES];
    logic cfg_chain [NUM_RULES];
    lre_out_kind_t cfg_kind [NUM_RULES];
    logic [SRC_IDX_W-1:0] cfg_oidx [NUM_RULES];
    logic [MOD_ID_W-1:0] cfg_omod [NUM_RULES];
    logic cfg_tv [NUM_RULES];

    lre_state_t state;
    logic [RULE_IDX_W-1:0] idx;
    logic [NUM_FLAGS-1:0] flags;
    logic res [NUM_RULES];
    logic fin [NUM_RULES];
    logic [NUM_INPUTS-1:0] in_seen [NUM_RULES];
    logic [1:0] stage [NUM_RULES];
    logic chain_val;
    logic chain_vld;
    logic [CYC_CNT_W-1:0] cyc_cnt;
    logic [CYC_CNT_W-1:0] cyc_target;
    logic start_take;
    logic [NUM_INPUTS-1:0] raw;
    logic [NUM_INPUTS-1:0] cond;
    logic eval_res;
    logic next_fin;
    logic cur_act;
    logic need_remote;
    logic out_advance;
    logic flag_wr;
    logic flag_val;
    int n_en;

    // Config only while idle so a running cycle never sees a half-written rule
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            for (int r = 0; r < NUM_RULES; r++)
            begin
                cfg_en[r] <= 1'b0;
                cfg_src[r] <= '0;
                cfg_idx[r] <= '0;
                cfg_used[r] <= '0;
                cfg_inv[r] <= '0;
                cfg_op[r] <= OP_AND;
                cfg_chain[r] <= 1'b0;
                cfg_kind[r] <= OUT_NONE;
                cfg_oidx[r] <= '0;
                cfg_omod[r] <= '0;
                cfg_tv[r] <= 1'b0;
            end
        end
        else if (cfg_we_i && state == ST_IDLE)
        begin
            cfg_en[cfg_rule_i] <= cfg_enable_i;
            cfg_src[cfg_rule_i] <= cfg_src_flag_i;
            cfg_idx[cfg_rule_i] <= cfg_in_idx_i;
            cfg_used[cfg_rule_i] <= cfg_in_used_i;
            cfg_inv[cfg_rule_i] <= cfg_in_invert_i;
            cfg_op[cfg_rule_i] <= cfg_op_i;
            cfg_chain[cfg_rule_i] <= cfg_chain_to_next_rule_i;
            cfg_kind[cfg_rule_i] <= cfg_out_kind_i;
            cfg_oidx[cfg_rule_i] <= cfg_out_idx_i;
            cfg_omod[cfg_rule_i] <= cfg_out_module_i;
            cfg_tv[cfg_rule_i] <= cfg_true_val_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Evaluation datapath for the rule under the index

    always_comb
    begin
        for (int k = 0; k < NUM_INPUTS; k++)
        begin
            if (cfg_src[idx][k])
                raw[k] = flags[cfg_idx[idx][k*SRC_IDX_W +: SRC_IDX_W]];
            else
                raw[k] = hw_in_i[cfg_idx[idx][k*SRC_IDX_W +: SRC_IDX_W]];
        end
    end

    lre_rule_eval #(
        .N_IN(NUM_INPUTS)
    ) u_eval (
        .raw_i(raw),
        .used_i(cfg_used[idx]),
        .invert_i(cfg_inv[idx]),
        .op_i(cfg_op[idx]),
        .cond_o(cond),
        .result_o(eval_res)
    );

    // Chained value folds in with the AND or OR family of the receiving rule
    always_comb
    begin
        next_fin = res[idx];
        if (chain_vld)
        begin
            if (cfg_op[idx] == OP_AND || cfg_op[idx] == OP_NAND)
                next_fin = res[idx] & chain_val;
            else
                next_fin = res[idx] | chain_val;
        end
    end

    assign cur_act = cfg_en[idx] && !cfg_chain[idx];
    assign need_remote = state == ST_OUT && cur_act && cfg_kind[idx] == OUT_REMOTE;
    assign out_advance = !need_remote || (net_tx_valid_o && net_tx_ready_i);
    assign flag_wr = state == ST_OUT && cur_act && cfg_kind[idx] == OUT_FLAG;
    assign flag_val = fin[idx] ? cfg_tv[idx] : ~cfg_tv[idx];
    assign start_take = start_rule_engine_i && state == ST_IDLE;

    always_comb
    begin
        n_en = 0;
        for (int r = 0; r < NUM_RULES; r++)
            n_en = n_en + (cfg_en[r] ? 1 : 0);
    end

    ////////////////////////////////////////////////////////////////////////
    // Stage sequencer

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            state <= ST_IDLE;
            idx <= '0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                    if (start_take)
                        state <= ST_EVAL;
                ST_EVAL:
                begin
                    idx <= idx + 4'h1;
                    if (idx == LAST_RULE)
                        state <= ST_EXEC;
                end
                ST_EXEC:
                begin
                    idx <= idx + 4'h1;
                    if (idx == LAST_RULE)
                        state <= ST_OUT;
                end
                ST_OUT:
                    if (out_advance)
                    begin
                        idx <= idx + 4'h1;
                        if (idx == LAST_RULE)
                            state <= ST_WAIT;
                    end
                ST_WAIT:
                    if (cyc_cnt >= cyc_target - 20'h1)
                        state <= stop_i ? ST_IDLE : ST_EVAL;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Cycle length fixed at start from the enabled count
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            cyc_cnt <= '0;
            cyc_target <= '0;
        end
        else
        begin
            if (start_take)
                cyc_target <= CYC_CNT_W'(FIXED_CYC + n_en * PER_RULE_CYC);
            if (state == ST_IDLE || (state == ST_WAIT && cyc_cnt >= cyc_target - 20'h1))
                cyc_cnt <= '0;
            else
                cyc_cnt <= cyc_cnt + 20'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-rule results, chaining and monitor state

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            chain_val <= 1'b0;
            chain_vld <= 1'b0;
            for (int r = 0; r < NUM_RULES; r++)
            begin
                res[r] <= 1'b0;
                fin[r] <= 1'b0;
                in_seen[r] <= '0;
                stage[r] <= STAGE_NONE;
            end
        end
        else
        begin
            if (start_take)
                for (int r = 0; r < NUM_RULES; r++)
                    stage[r] <= STAGE_NONE;
            if (state == ST_EVAL && cfg_en[idx])
            begin
                res[idx] <= eval_res;
                in_seen[idx] <= cond;
                stage[idx] <= STAGE_COND;
            end
            if (state == ST_EXEC)
            begin
                if (cfg_en[idx])
                begin
                    fin[idx] <= next_fin;
                    stage[idx] <= STAGE_EXEC;
                end
                // Chain reaches only the next index; a gap drops it
                chain_vld <= cfg_en[idx] && cfg_chain[idx];
                chain_val <= next_fin;
            end
            else
                chain_vld <= 1'b0;
            if (state == ST_OUT && cfg_en[idx] && out_advance)
                stage[idx] <= STAGE_OUT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags, hardware outputs and remote sends

    // Rule output wins over host and network in the same cycle
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            flags <= '0;
        else if (start_take)
            flags <= '0;
        else
        begin
            if (net_rx_we_i && running_o)
                flags[net_rx_idx_i] <= net_rx_val_i;
            if (host_flag_we_i && running_o && monitor_en_i)
                flags[host_flag_idx_i] <= host_flag_val_i;
            if (flag_wr)
                flags[cfg_oidx[idx]] <= flag_val;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            hw_out_o <= '0;
        else if (state == ST_OUT && cur_act && cfg_kind[idx] == OUT_HW)
            hw_out_o[cfg_oidx[idx]] <= flag_val;
    end

    // Send is held until the network accepts; the walk stalls meanwhile
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            net_tx_valid_o <= 1'b0;
            net_tx_module_o <= '0;
            net_tx_idx_o <= '0;
            net_tx_val_o <= 1'b0;
        end
        else if (net_tx_valid_o)
        begin
            if (net_tx_ready_i)
                net_tx_valid_o <= 1'b0;
        end
        else if (need_remote)
        begin
            net_tx_valid_o <= 1'b1;
            net_tx_module_o <= cfg_omod[idx];
            net_tx_idx_o <= cfg_oidx[idx];
            net_tx_val_o <= flag_val;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            running_o <= 1'b0;
            rule_stage_o <= '0;
            rule_inputs_o <= '0;
        end
        else
        begin
            running_o <= state != ST_IDLE || start_take;
            for (int r = 0; r < NUM_RULES; r++)
            begin
                rule_stage_o[r*2 +: 2] <= (monitor_en_i && running_o) ? stage[r] : STAGE_NONE;
                rule_inputs_o[r*NUM_INPUTS +: NUM_INPUTS] <= (monitor_en_i && running_o) ? in_seen[r] : '0;
            end
        end
    end

    assign flags_o = flags;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_eval_done;
        state == ST_EVAL && idx == LAST_RULE;
    endsequence

    sequence s_exec_done;
        state == ST_EXEC && idx == LAST_RULE;
    endsequence

    property p_eval_to_exec;
        s_eval_done |=> state == ST_EXEC && idx == 4'h0;
    endproperty
    a_eval_to_exec: assert property (p_eval_to_exec) else $error("exec did not follow eval group");

    property p_exec_to_out;
        s_exec_done |=> state == ST_OUT && idx == 4'h0;
    endproperty
    a_exec_to_out: assert property (p_exec_to_out) else $error("output did not follow exec group");

    property p_index_step;
        (state == ST_EXEC && idx != LAST_RULE) |=> idx == $past(idx) + 4'h1;
    endproperty
    a_index_step: assert property (p_index_step) else $error("rule index skipped");

    property p_run_start;
        $rose(running_o) |-> $past(start_rule_engine_i) && flags == '0;
    endproperty
    a_run_start: assert property (p_run_start) else $error("run without command or flags not clear");

    property p_flag_write;
        flag_wr |=> flags[$past(cfg_oidx[idx])] == ($past(fin[idx]) == $past(cfg_tv[idx]));
    endproperty
    a_flag_write: assert property (p_flag_write) else $error("flag not written with true or complement");

    property p_host_flag;
        (host_flag_we_i && running_o && monitor_en_i && !flag_wr && !start_take && !net_rx_we_i)
            |=> flags[$past(host_flag_idx_i)] == $past(host_flag_val_i);
    endproperty
    a_host_flag: assert property (p_host_flag) else $error("host flag toggle lost");

    property p_monitor_off;
        !monitor_en_i |=> rule_stage_o == '0 && rule_inputs_o == '0;
    endproperty
    a_monitor_off: assert property (p_monitor_off) else $error("monitor data shown while disabled");

    // A sequence cannot be an operand of a logical and, so the step is its own sequence
    sequence s_wait_to_eval;
        state == ST_WAIT ##1 state == ST_EVAL;
    endsequence

    property p_cycle_len;
        s_wait_to_eval |-> $past(cyc_cnt) == cyc_target - 20'h1;
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("cycle length wrong");

    property p_tx_hold;
        (net_tx_valid_o && !net_tx_ready_i) |=> net_tx_valid_o && $stable(net_tx_idx_o) && $stable(net_tx_val_o);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("remote send dropped before accept");

endmodule

`default_nettype wire

// ==== inc/lre_pkg.sv ====
package lre_pkg;

    localparam int NUM_RULES = 16;
    localparam int NUM_INPUTS = 3;
    localparam int NUM_FLAGS = 16;
    localparam int NUM_HW_IN = 16;
    localparam int NUM_HW_OUT = 16;
    localparam int RULE_IDX_W = 4;
    localparam int SRC_IDX_W = 4;
    localparam int MOD_ID_W = 8;
    localparam int CYC_CNT_W = 20;

    localparam int CLK_FREQ_KHZ = 40000;
    localparam int CYCLE_FIXED_US = 600;
    localparam int RULE_TIME_US = 370;
    localparam int CYCLE_FIXED_CYC = CYCLE_FIXED_US * CLK_FREQ_KHZ / 1000;
    localparam int RULE_TIME_CYC = RULE_TIME_US * CLK_FREQ_KHZ / 1000;

    localparam logic [1:0] STAGE_NONE = 2'h0;
    localparam logic [1:0] STAGE_COND = 2'h1;
    localparam logic [1:0] STAGE_EXEC = 2'h2;
    localparam logic [1:0] STAGE_OUT = 2'h3;

    localparam logic [RULE_IDX_W-1:0] LAST_RULE = 4'hF;

    typedef enum logic [1:0] {
        OP_AND,
        OP_OR,
        OP_NAND,
        OP_NOR
    } lre_op_t;

    typedef enum logic [1:0] {
        OUT_NONE,
        OUT_HW,
        OUT_FLAG,
        OUT_REMOTE
    } lre_out_kind_t;

    typedef enum {
        ST_IDLE,
        ST_EVAL,
        ST_EXEC,
        ST_OUT,
        ST_WAIT
    } lre_state_t;

endpackage

// ==== src/lre_rule_eval.sv ====
`timescale 1ns/100ps
`default_nettype none

module lre_rule_eval
    import lre_pkg::*;
#(
    parameter int N_IN = lre_pkg::NUM_INPUTS
)
(
    input wire logic [N_IN-1:0] raw_i,
    input wire logic [N_IN-1:0] used_i,
    input wire logic [N_IN-1:0] invert_i,
    input wire lre_pkg::lre_op_t op_i,
    output logic [N_IN-1:0] cond_o,
    output logic result_o
);

    logic all_true;
    logic any_true;

    always_comb
    begin
        all_true = 1'b1;
        any_true = 1'b0;
        for (int k = 0; k < N_IN; k++)
        begin
            cond_o[k] = raw_i[k] ^ invert_i[k];
            if (used_i[k])
            begin
                all_true = all_true & cond_o[k];
                any_true = any_true | cond_o[k];
            end
        end
        case (op_i)
            OP_AND: result_o = all_true;
            OP_OR: result_o = any_true;
            OP_NAND: result_o = ~all_true;
            OP_NOR: result_o = ~any_true;
            default: result_o = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// ==== verification/lre_net_peer.sv ====
`timescale 1ns/100ps
`default_nettype none

module lre_net_peer
    import lre_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic net_tx_valid_i,
    input wire logic [lre_pkg::MOD_ID_W-1:0] net_tx_module_i,
    input wire logic [lre_pkg::SRC_IDX_W-1:0] net_tx_idx_i,
    input wire logic net_tx_val_i,
    input wire logic [3:0] stall_i,
    output logic net_tx_ready_o,
    output logic [lre_pkg::MOD_ID_W-1:0] last_module_o,
    output logic [lre_pkg::SRC_IDX_W-1:0] last_idx_o,
    output logic last_val_o
);
    logic [3:0] wait_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // Ready only after a chosen stall, so a slow switch is exercised too
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            net_tx_ready_o <= 1'b0;
            wait_cnt <= 4'h0;
            last_module_o <= '0;
            last_idx_o <= '0;
            last_val_o <= 1'b0;
        end
        else if (net_tx_valid_i && net_tx_ready_o)
        begin
            net_tx_ready_o <= 1'b0;
            wait_cnt <= 4'h0;
            last_module_o <= net_tx_module_i;
            last_idx_o <= net_tx_idx_i;
            last_val_o <= net_tx_val_i;
        end
        else if (net_tx_valid_i)
        begin
            if (wait_cnt >= stall_i)
                net_tx_ready_o <= 1'b1;
            else
                wait_cnt <= wait_cnt + 4'h1;
        end
        else
            net_tx_ready_o <= 1'b0;
    end
endmodule

`default_nettype wire

// ==== verification/lre_engine_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module lre_engine_tb;
    import lre_pkg::*;
    // Short cycle keeps the run small; eight rules enabled
    localparam int FIX = 100;
    localparam int PER = 10;
    localparam int CYC = FIX + 8 * PER;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic start = 1'b0, stop = 1'b0, mon = 1'b1, cfg_we = 1'b0, chain = 1'b0, tv = 1'b0;
    logic hwe = 1'b0, nwe = 1'b0, fval = 1'b0, en = 1'b1;
    logic [3:0] rule = 4'h0, oidx = 4'h0, fidx = 4'h0, stall = 4'h0;
    logic [2:0] src = 3'h0, used = 3'h0, inv = 3'h0;
    logic [11:0] idx = 12'h000;
    lre_op_t op = OP_AND;
    lre_out_kind_t kind = OUT_NONE;
    logic [15:0] hw_in = 16'h0000;
    logic running, tx_valid, tx_ready, tx_val, last_val;
    logic [15:0] hw_out, flags;
    logic [7:0] tx_mod, last_mod;
    logic [3:0] tx_idx, last_idx;
    logic [31:0] stage;
    logic [47:0] inputs;
    int num_errors = 0;
    int checked = 0;
    int n;

    always #12.5 core_clk_i = ~core_clk_i;

    lre_engine #(.FIXED_CYC(FIX), .PER_RULE_CYC(PER)) dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .start_rule_engine_i(start), .stop_i(stop), .running_o(running), .monitor_en_i(mon),
        .cfg_we_i(cfg_we), .cfg_rule_i(rule), .cfg_enable_i(en), .cfg_src_flag_i(src),
        .cfg_in_idx_i(idx), .cfg_in_used_i(used), .cfg_in_invert_i(inv), .cfg_op_i(op),
        .cfg_chain_to_next_rule_i(chain), .cfg_out_kind_i(kind), .cfg_out_idx_i(oidx),
        .cfg_out_module_i(8'h5A), .cfg_true_val_i(tv), .hw_in_i(hw_in), .hw_out_o(hw_out),
        .flags_o(flags), .host_flag_we_i(hwe), .host_flag_idx_i(fidx), .host_flag_val_i(fval),
        .net_rx_we_i(nwe), .net_rx_idx_i(fidx), .net_rx_val_i(fval),
        .net_tx_valid_o(tx_valid), .net_tx_ready_i(tx_ready), .net_tx_module_o(tx_mod),
        .net_tx_idx_o(tx_idx), .net_tx_val_o(tx_val), .rule_stage_o(stage), .rule_inputs_o(inputs)
    );

    lre_net_peer peer (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .net_tx_valid_i(tx_valid),
        .net_tx_module_i(tx_mod), .net_tx_idx_i(tx_idx), .net_tx_val_i(tx_val), .stall_i(stall),
        .net_tx_ready_o(tx_ready), .last_module_o(last_mod), .last_idx_o(last_idx), .last_val_o(last_val)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk_i);
    endtask

    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check_vec(input logic [95:0] got, input logic [95:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_int(input int got, input int exp);
        checked++;
        if (got != exp)
        begin
            num_errors++;
            $display("[FAIL] %0t count %0d exp %0d", $time, got, exp);
        end
    endtask

    task automatic cfg(input logic [3:0] r, input logic [2:0] s, input logic [11:0] ix, input logic [2:0] u,
                       input logic [2:0] iv, input lre_op_t o, input logic ch, input lre_out_kind_t k,
                       input logic [3:0] oi, input logic t);
        @(posedge core_clk_i);
        rule <= r;
        src <= s;
        idx <= ix;
        used <= u;
        inv <= iv;
        op <= o;
        chain <= ch;
        kind <= k;
        oidx <= oi;
        tv <= t;
        cfg_we <= 1'b1;
        @(posedge core_clk_i);
        cfg_we <= 1'b0;
    endtask

    // Host and network writers share index and value lines
    task automatic flag_wr(input logic net, input logic [3:0] i, input logic v);
        @(posedge core_clk_i);
        fidx <= i;
        fval <= v;
        hwe <= !net;
        nwe <= net;
        @(posedge core_clk_i);
        hwe <= 1'b0;
        nwe <= 1'b0;
    endtask

    function automatic logic sig(input int id);
        return (id == 0) ? flags[0] : (id == 1) ? flags[1] : running;
    endfunction

    task automatic wait_change(input int id, output int cnt);
        logic prev;
        prev = sig(id);
        cnt = 0;
        while (sig(id) === prev && cnt < 3 * CYC)
        begin
            @(posedge core_clk_i);
            #1;
            cnt++;
        end
        if (cnt >= 3 * CYC)
        begin
            num_errors++;
            $display("[FAIL] %0t wait ran out", $time);
            summarize();
        end
    endtask

    task automatic run_start();
        tick(1);
        start <= 1'b1;
        tick(1);
        start <= 1'b0;
        tick(1);
        @(negedge core_clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(2);
        rst_n_i <= 1'b1;
        @(negedge core_clk_i);
        check_vec({running, hw_out, flags}, '0);
        cfg(4'h0, 3'b000, 12'h710, 3'b111, 3'b000, OP_AND, 1'b0, OUT_FLAG, 4'h0, 1'b1);
        cfg(4'h1, 3'b001, 12'h000, 3'b001, 3'b000, OP_OR, 1'b0, OUT_HW, 4'h0, 1'b1);
        cfg(4'h2, 3'b001, 12'h001, 3'b001, 3'b001, OP_AND, 1'b0, OUT_FLAG, 4'h1, 1'b1);
        cfg(4'h3, 3'b000, 12'h002, 3'b001, 3'b000, OP_AND, 1'b0, OUT_REMOTE, 4'h3, 1'b0);
        cfg(4'h4, 3'b000, 12'h003, 3'b001, 3'b000, OP_AND, 1'b1, OUT_NONE, 4'h0, 1'b0);
        cfg(4'h5, 3'b000, 12'h004, 3'b001, 3'b000, OP_AND, 1'b0, OUT_HW, 4'h1, 1'b1);
        cfg(4'h6, 3'b001, 12'h005, 3'b001, 3'b000, OP_NAND, 1'b0, OUT_HW, 4'h2, 1'b1);
        cfg(4'h7, 3'b000, 12'h005, 3'b001, 3'b000, OP_NOR, 1'b0, OUT_HW, 4'h3, 1'b1);
        tick(1);
        hw_in <= 16'h0083;
        tick(40);
        @(negedge core_clk_i);
        check_vec({running, hw_out}, '0);
        run_start();
        check_vec({running, flags}, {1'b1, 16'h0000});
        wait_change(0, n);
        tick(5);
        @(negedge core_clk_i);
        check_vec(hw_out[0], 1'b0);
        check_vec(stage[1:0], STAGE_OUT);
        check_vec(inputs[2:0], 3'b111);
        tick(CYC);
        @(negedge core_clk_i);
        check_vec(hw_out[0], 1'b1);
        check_vec({last_mod, last_idx, last_val}, {8'h5A, 4'h3, 1'b1});
        tick(1);
        stall <= 4'h6;
        hw_in[2] <= 1'b1;
        wait_change(1, n);
        wait_change(1, n);
        check_int(n, CYC);
        tick(CYC);
        @(negedge core_clk_i);
        check_vec({last_mod, last_idx, last_val}, {8'h5A, 4'h3, 1'b0});
        for (int i = 0; i < 4; i++)
        begin
            tick(1);
            hw_in[3] <= i[0];
            hw_in[4] <= i[1];
            hw_in[5] <= i[0];
            tick(2 * CYC);
            @(negedge core_clk_i);
            check_vec(hw_out[3:1], {~i[0], 1'b1, i == 3});
        end
        flag_wr(1'b0, 4'h5, 1'b1);
        tick(2 * CYC);
        @(negedge core_clk_i);
        check_vec({hw_out[2], flags[5]}, 2'b01);
        tick(1);
        mon <= 1'b0;
        flag_wr(1'b0, 4'h5, 1'b0);
        tick(2);
        @(negedge core_clk_i);
        check_vec({flags[5], stage, inputs}, {1'b1, 80'h0});
        tick(1);
        mon <= 1'b1;
        flag_wr(1'b1, 4'h6, 1'b1);
        tick(2);
        @(negedge core_clk_i);
        check_vec(flags[6], 1'b1);
        // Rewrite while running must be ignored
        cfg(4'h1, 3'b001, 12'h000, 3'b001, 3'b000, OP_OR, 1'b0, OUT_HW, 4'h9, 1'b1);
        tick(2 * CYC);
        @(negedge core_clk_i);
        check_vec({hw_out[9], hw_out[0]}, 2'b01);
        tick(1);
        stop <= 1'b1;
        wait_change(2, n);
        tick(1);
        stop <= 1'b0;
        tick(20);
        @(negedge core_clk_i);
        check_vec(running, 1'b0);
        // Unused slot must neither write its output nor count in the cycle length
        tick(1);
        en <= 1'b0;
        hw_in[5] <= 1'b0;
        cfg(4'h7, 3'b000, 12'h005, 3'b001, 3'b000, OP_NOR, 1'b0, OUT_HW, 4'h3, 1'b1);
        en <= 1'b1;
        run_start();
        check_vec({running, flags}, {1'b1, 16'h0000});
        wait_change(1, n);
        wait_change(1, n);
        check_int(n, FIX + 7 * PER);
        check_vec(hw_out[3], 1'b0);
        summarize();
    end
endmodule

`default_nettype wire
